/* File: core/cswl_defines.svh */
/*
  Constants of the sleep, wake and lockup controller: register offsets,
  field positions and reset values.
  Assumes inclusion by bare name from the design modules and the bench.
*/
`ifndef CSWL_DEFINES_SVH
`define CSWL_DEFINES_SVH

`define CSWL_ADDR_W            4
`define CSWL_DATA_W            32
`define CSWL_OFF_SYSCTRL       4'h0
`define CSWL_OFF_STATUS        4'h4
`define CSWL_OFF_ID            4'h8
`define CSWL_BIT_SLEEP_AFTER   1
`define CSWL_BIT_DEEP_SELECT   2
`define CSWL_BIT_PEND_EVENT    4
`define CSWL_SYSCTRL_MASK      32'h0000_0016
`define CSWL_SYSCTRL_RST       32'h0000_0000
`define CSWL_ST_LOCKUP         0
`define CSWL_ST_SLEEP          1
`define CSWL_ST_DEEP           2
`define CSWL_ST_NMI_LOCK       3
// Identification word: the value is arbitrary
`define CSWL_ID_VALUE          32'h0000_5A01

`endif

/* File: core/cswl_pkg.sv */
/*
  Types of the sleep, wake and lockup controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cswl_pkg;

  typedef enum logic [1:0] {
    CSWL_RUN,
    CSWL_SLEEP_IRQ,
    CSWL_SLEEP_EVT,
    CSWL_LOCKUP
  } cswl_state_t;

endpackage

/* File: core/cswl_event_latch.sv */
/*
  Hidden one-bit event latch that decides whether a wait-for-event sleeps.
  Assumes all inputs are synchronous to sys_clk_i.
*/
`timescale 1ns/10ps

module cswl_event_latch
  import cswl_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  // Event sources
  input  wire logic set_i,
  // Consumption by a wait-for-event
  input  wire logic clear_i,
  // Latch state
  output logic      latched_o
);

  logic event_r;

  // Set wins over clear so a coincident event is never lost
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      event_r <= 1'b0;
    end else if (set_i) begin
      event_r <= 1'b1;
    end else if (clear_i) begin
      event_r <= 1'b0;
    end
  end

  assign latched_o = event_r;

  a_set_holds: assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i) set_i |=> event_r)
    else $error("event latch missed a set");

endmodule // cswl_event_latch

/* File: core/cswl_regs.sv */
/*
  Software register file: system control bits and read-only status.
  Assumes a plain strobe port whose master never waits.
*/
`timescale 1ns/10ps
`include "cswl_defines.svh"

module cswl_regs
  import cswl_pkg::*;
(
  // Clock and reset
  input  wire logic                      sys_clk_i,
  input  wire logic                      arst_n_i,
  // Register port
  input  wire logic [`CSWL_ADDR_W-1:0]   addr_i,
  input  wire logic [`CSWL_DATA_W-1:0]   wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output logic      [`CSWL_DATA_W-1:0]   rdata_o,
  // Block state
  input  wire logic [3:0]                status_i,
  output logic      [`CSWL_DATA_W-1:0]   sysctrl_o
);

  logic [`CSWL_DATA_W-1:0] sysctrl_r;
  logic [`CSWL_DATA_W-1:0] rdata_r;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sysctrl_r <= `CSWL_SYSCTRL_RST;
    end else if (wr_i && addr_i == `CSWL_OFF_SYSCTRL) begin
      sysctrl_r <= wdata_i & `CSWL_SYSCTRL_MASK;
    end
  end

  // Unmapped offsets and idle cycles read as zero
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_r <= '0;
    end else if (rd_i) begin
      unique case (addr_i)
        `CSWL_OFF_SYSCTRL: rdata_r <= sysctrl_r;
        `CSWL_OFF_STATUS:  rdata_r <= {28'h000_0000, status_i};
        `CSWL_OFF_ID:      rdata_r <= `CSWL_ID_VALUE; // arbitrary value
        default:           rdata_r <= '0;
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  assign sysctrl_o = sysctrl_r;
  assign rdata_o   = rdata_r;

  a_read_once: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !rd_i |=> rdata_r == '0) else $error("read data outside read slot");

endmodule // cswl_regs

/* File: core/cswl_ctrl.sv */
/*
  Sleep, wake and lockup controller of a processor core.
  Assumes exception, debug and instruction-issue strobes are one-cycle
  pulses synchronous to sys_clk_i, and that the exception logic decides
  priority: wake_exc_i already means "able to cause exception entry".
*/
`timescale 1ns/10ps
`include "cswl_defines.svh"

// Overview of operation
// - Hard fault inside NMI or hard-fault handler enters lockup.
// - Lockup issues nothing; left by reset, NMI or debugger halt.
// - Lockup entered from NMI handler ignores further NMIs.
// - Light sleep gates only the processor clock.
// - Deep sleep also requests most system clocks stopped.
// - Deep-sleep select bit chooses light or deep sleep.
// - Wait-for-interrupt sleeps at once unless a wake is already true.
// - Wait-for-event with latch clear sleeps unless a wake or an event is already true.
// - Wait-for-event with latch set clears it and continues.
// - Event latch is one bit, hidden from software.
// - Latch set by external event or another core's send-event.
// - Sleep-after-handler sleeps on return to thread mode.
// - Interrupt-style sleep wakes on an enterable exception, a masked wake or debug halt.
// - Masked higher-priority interrupt wakes; handler waits for unmask.
// - Event sleep wakes on exception, event input or send-event.
// - Pending-sets-event makes any new pending interrupt an event.
// - Event input wakes event sleep or else sets the latch.
module cswl_ctrl
  import cswl_pkg::*;
(
  // Clock and reset
  input  wire logic                     sys_clk_i,
  input  wire logic                     arst_n_i,
  // Register port
  input  wire logic [`CSWL_ADDR_W-1:0]  reg_addr_i,
  input  wire logic [`CSWL_DATA_W-1:0]  reg_wdata_i,
  input  wire logic                     reg_wr_i,
  input  wire logic                     reg_rd_i,
  output logic      [`CSWL_DATA_W-1:0]  reg_rdata_o,
  // Instruction issue
  input  wire logic                     wait_interrupt_instr_i,
  input  wire logic                     wait_event_instr_i,
  input  wire logic                     handler_exit_i,
  // Exception logic
  input  wire logic                     hard_fault_i,
  input  wire logic                     in_nmi_handler_i,
  input  wire logic                     in_hardfault_handler_i,
  input  wire logic                     nmi_i,
  input  wire logic                     wake_exc_i,
  input  wire logic                     masked_irq_wake_i,
  input  wire logic                     new_pending_i,
  input  wire logic                     priority_mask_bit_i,
  input  wire logic                     fault_mask_bit_i,
  // Events and debug
  input  wire logic                     ext_event_i,
  input  wire logic                     send_event_other_i,
  input  wire logic                     debug_halt_i,
  // Status and clock control
  output logic                          issue_en_o,
  output logic                          cpu_clk_gate_o,
  output logic                          sys_clk_stop_o,
  output logic                          sleeping_o,
  output logic                          deep_sleeping_o,
  output logic                          lockup_o,
  output logic                          event_consumed_o
);

  cswl_state_t             state_r;
  cswl_state_t             state_nxt;
  logic                    nmi_lock_r;
  logic                    issue_en_r;
  logic                    cpu_gate_r;
  logic                    sys_stop_r;
  logic                    sleeping_r;
  logic                    deep_r;
  logic                    lockup_r;
  logic                    consumed_r;
  logic [`CSWL_DATA_W-1:0] sysctrl;
  logic                    event_latched;
  logic                    event_set;
  logic                    event_clr;
  logic                    event_src;
  logic                    irq_wake;
  logic                    deep_sel;
  logic                    lock_enter;
  logic                    lock_leave;
  logic [3:0]              status;

  // Every check below runs on the core clock and rests during reset
  default clocking cb_chk @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // Either sleep state gates the core clock
  function automatic logic asleep(input cswl_state_t s);
    return s == CSWL_SLEEP_IRQ || s == CSWL_SLEEP_EVT;
  endfunction

  assign deep_sel = sysctrl[`CSWL_BIT_DEEP_SELECT];

  // Masked-interrupt wake only counts with priority mask set, fault mask clear
  assign irq_wake = wake_exc_i ||
                    (masked_irq_wake_i && priority_mask_bit_i &&
                     !fault_mask_bit_i);

  assign event_src = ext_event_i || send_event_other_i ||
                     (new_pending_i && sysctrl[`CSWL_BIT_PEND_EVENT]);

  assign lock_enter = hard_fault_i &&
                      (in_nmi_handler_i || in_hardfault_handler_i);
  assign lock_leave = debug_halt_i || (nmi_i && !nmi_lock_r);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CSWL_RUN: begin
        if (lock_enter) begin
          state_nxt = CSWL_LOCKUP;
        end else if (wait_interrupt_instr_i && !irq_wake) begin
          state_nxt = CSWL_SLEEP_IRQ;
        end else if (handler_exit_i && sysctrl[`CSWL_BIT_SLEEP_AFTER] &&
                     !irq_wake) begin
          state_nxt = CSWL_SLEEP_IRQ;
        end else if (wait_event_instr_i && !event_latched &&
                     !event_src && !irq_wake) begin
          state_nxt = CSWL_SLEEP_EVT;
        end
      end
      CSWL_SLEEP_IRQ: begin
        if (irq_wake || debug_halt_i) begin
          state_nxt = CSWL_RUN;
        end
      end
      CSWL_SLEEP_EVT: begin
        if (irq_wake || event_src || debug_halt_i) begin
          state_nxt = CSWL_RUN;
        end
      end
      CSWL_LOCKUP: begin
        if (lock_leave) begin
          state_nxt = CSWL_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= CSWL_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Remember which handler locked up so a later NMI cannot release it
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      nmi_lock_r <= 1'b0;
    end else if (state_r == CSWL_RUN && lock_enter) begin
      nmi_lock_r <= in_nmi_handler_i;
    end else if (state_nxt != CSWL_LOCKUP) begin
      nmi_lock_r <= 1'b0;
    end
  end

  // Latch is set in every state but event sleep; there the event wakes instead
  assign event_set = event_src && state_r != CSWL_SLEEP_EVT;
  assign event_clr = state_r == CSWL_RUN && wait_event_instr_i &&
                     event_latched && !lock_enter;

  cswl_event_latch u_latch (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .set_i     (event_set),
    .clear_i   (event_clr),
    .latched_o (event_latched)
  );

  assign status = {nmi_lock_r, deep_r, sleeping_r, lockup_r};

  cswl_regs u_regs (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .addr_i    (reg_addr_i),
    .wdata_i   (reg_wdata_i),
    .wr_i      (reg_wr_i),
    .rd_i      (reg_rd_i),
    .rdata_o   (reg_rdata_o),
    .status_i  (status),
    .sysctrl_o (sysctrl)
  );

  // Outputs registered from the next state, so they align with state_r
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      issue_en_r <= 1'b1;
      cpu_gate_r <= 1'b0;
      sys_stop_r <= 1'b0;
      sleeping_r <= 1'b0;
      deep_r     <= 1'b0;
      lockup_r   <= 1'b0;
    end else begin
      issue_en_r <= state_nxt == CSWL_RUN;
      cpu_gate_r <= asleep(state_nxt);
      sys_stop_r <= asleep(state_nxt) && deep_sel;
      sleeping_r <= asleep(state_nxt);
      deep_r     <= asleep(state_nxt) && deep_sel;
      lockup_r   <= state_nxt == CSWL_LOCKUP;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      consumed_r <= 1'b0;
    end else begin
      consumed_r <= event_clr;
    end
  end

  assign issue_en_o       = issue_en_r;
  assign cpu_clk_gate_o   = cpu_gate_r;
  assign sys_clk_stop_o   = sys_stop_r;
  assign sleeping_o       = sleeping_r;
  assign deep_sleeping_o  = deep_r;
  assign lockup_o         = lockup_r;
  assign event_consumed_o = consumed_r;

  sequence s_running;
    state_r == CSWL_RUN;
  endsequence

  sequence s_sleeping;
    sleeping_r && !issue_en_r;
  endsequence

  // Plain entry into event sleep: nothing of higher priority that cycle
  sequence s_evt_entry;
    s_running ##0 (wait_event_instr_i && !event_latched && !event_src &&
                   !irq_wake && !lock_enter && !wait_interrupt_instr_i &&
                   !handler_exit_i);
  endsequence

  a_lock_enter: assert property (
    s_running ##0 lock_enter |=> lockup_r && !issue_en_r)
    else $error("lockup not entered");
  a_lock_stays: assert property (
    lockup_r && !debug_halt_i && !nmi_i |=> lockup_r && !issue_en_r)
    else $error("lockup left without cause");
  a_nmi_locked: assert property (
    lockup_r && nmi_lock_r && !debug_halt_i |=> lockup_r)
    else $error("nmi released nmi lockup");
  a_nmi_leaves: assert property (
    lockup_r && !nmi_lock_r && nmi_i |=> !lockup_r && issue_en_r)
    else $error("nmi did not end lockup");
  a_halt_leaves: assert property (
    lockup_r && debug_halt_i |=> !lockup_r && issue_en_r)
    else $error("debug halt did not end lockup");
  a_light_gate: assert property (
    cpu_clk_gate_o && !deep_r |-> !sys_clk_stop_o)
    else $error("light sleep stopped system clocks");
  a_deep_stop: assert property (
    deep_r |-> sys_clk_stop_o && cpu_clk_gate_o)
    else $error("deep sleep kept clocks");
  a_irq_sleep: assert property (
    s_running ##0 (wait_interrupt_instr_i && !irq_wake && !lock_enter)
    |=> s_sleeping ##0 (deep_r == $past(deep_sel)))
    else $error("wait-for-interrupt did not sleep");
  a_irq_stays_awake: assert property (
    s_running ##0 (wait_interrupt_instr_i && irq_wake && !lock_enter)
    |=> issue_en_r && !sleeping_r)
    else $error("wait-for-interrupt slept with a wake pending");
  a_evt_sleep: assert property (
    s_evt_entry |=> s_sleeping ##0 (state_r == CSWL_SLEEP_EVT))
    else $error("wait-for-event did not sleep");
  a_evt_skip: assert property (
    s_running ##0 (wait_event_instr_i && event_latched && !lock_enter &&
                   !wait_interrupt_instr_i && !handler_exit_i)
    |=> issue_en_r && (!event_latched || $past(event_set)))
    else $error("wait-for-event with latch set misbehaved");
  a_latch_sets: assert property (
    s_running ##0 ext_event_i |=> event_latched)
    else $error("event input while awake left latch clear");
  a_after_handler: assert property (
    s_running ##0 (handler_exit_i && sysctrl[`CSWL_BIT_SLEEP_AFTER] &&
                   !irq_wake && !lock_enter)
    |=> s_sleeping)
    else $error("handler exit did not sleep");
  a_evt_wake: assert property (
    state_r == CSWL_SLEEP_EVT && event_src |=> issue_en_r && !sleeping_r)
    else $error("event did not wake");
  a_pend_event: assert property (
    state_r == CSWL_SLEEP_EVT && new_pending_i &&
    sysctrl[`CSWL_BIT_PEND_EVENT] |=> issue_en_r)
    else $error("new pending interrupt did not wake");
  a_masked_wake: assert property (
    state_r == CSWL_SLEEP_IRQ && masked_irq_wake_i && priority_mask_bit_i &&
    !fault_mask_bit_i |=> issue_en_r)
    else $error("masked interrupt did not wake");
  a_irq_hold: assert property (
    state_r == CSWL_SLEEP_IRQ && !irq_wake && !debug_halt_i
    |=> sleeping_r[*1])
    else $error("interrupt sleep woke without exception");

endmodule // cswl_ctrl

/* File: tb/cswl_evt_src.sv */
/* Far-side event sources: the external event controller and a second
   processor that executes send-event. Assumes the core clock. */
`timescale 1ns/10ps

module cswl_evt_src (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  // Bench commands
  input  wire logic fire_ext_i,
  input  wire logic fire_sev_i,
  // Lines into the core
  output logic      ext_event_o,
  output logic      send_event_o
);
  // Registered so the core never sees a pulse launched on its own edge
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_event_o <= 1'b0;
    end else begin
      ext_event_o <= fire_ext_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      send_event_o <= 1'b0;
    end else begin
      send_event_o <= fire_sev_i;
    end
  end
endmodule // cswl_evt_src

/* File: tb/core_sleep_wake_lockup_ctrl_test.sv */
/* Self-checking bench of the sleep, wake and lockup controller.
   Assumes the design and the event source model are compiled first. */
`timescale 1ns/10ps
`include "cswl_defines.svh"

module core_sleep_wake_lockup_ctrl_test;
  import cswl_pkg::*;
  logic        clk    = 1'b0;
  logic        arst_n = 1'b0;
  logic        rd     = 1'b0;
  logic        wr     = 1'b0;
  logic [3:0]  addr   = 4'h0;
  logic [31:0] wdata  = 32'h0;
  // 0 wait-irq 1 wait-evt 2 exit 3 fault 4 halt 5 pend 6 ext 7 peer
  logic [7:0]  pls    = 8'h00;
  // 6 in_nmi 5 in_hf 4 nmi 3 wake 2 masked 1 prio mask 0 fault mask
  logic [6:0]  lv     = 7'h00;
  wire  [31:0] rdata;
  wire  [5:0]  st;
  wire         ev_cons;
  wire         ext_ev;
  wire         peer_ev;
  int          error_cnt = 0;
  int          compares  = 0;
  int          cons_cnt  = 0;

  always #5 clk = ~clk;

  cswl_evt_src evt_u (.sys_clk_i(clk), .arst_n_i(arst_n),
    .fire_ext_i(pls[6]), .fire_sev_i(pls[7]),
    .ext_event_o(ext_ev), .send_event_o(peer_ev));

  cswl_ctrl dut_u (.sys_clk_i(clk), .arst_n_i(arst_n),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata),
    .wait_interrupt_instr_i(pls[0]), .wait_event_instr_i(pls[1]),
    .handler_exit_i(pls[2]), .hard_fault_i(pls[3]),
    .in_nmi_handler_i(lv[6]), .in_hardfault_handler_i(lv[5]),
    .nmi_i(lv[4]), .wake_exc_i(lv[3]), .masked_irq_wake_i(lv[2]),
    .new_pending_i(pls[5]), .priority_mask_bit_i(lv[1]),
    .fault_mask_bit_i(lv[0]), .ext_event_i(ext_ev),
    .send_event_other_i(peer_ev), .debug_halt_i(pls[4]),
    .issue_en_o(st[5]), .cpu_clk_gate_o(st[4]),
    .sys_clk_stop_o(st[3]), .sleeping_o(st[2]),
    .deep_sleeping_o(st[1]), .lockup_o(st[0]),
    .event_consumed_o(ev_cons));

  always @(posedge clk) begin
    if (ev_cons === 1'b1) begin
      cons_cnt++;
    end
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Bounded wait for a status pattern, then compare
  task automatic exp_st(input string n, input logic [5:0] e);
    int i;
    #1;
    for (i = 0; i < 4 && st !== e; i++) begin
      @(posedge clk);
      #1;
    end
    chk(n, {26'h0, e}, {26'h0, st});
  endtask

  // Status must still match after three cycles
  task automatic hold(input string n, input logic [5:0] e);
    repeat (3) @(posedge clk);
    #1;
    chk(n, {26'h0, e}, {26'h0, st});
  endtask

  task automatic pulse(input int b);
    @(posedge clk);
    pls[b] <= 1'b1;
    @(posedge clk);
    pls[b] <= 1'b0;
  endtask

  task automatic setlv(input logic [6:0] v);
    @(posedge clk);
    lv <= v;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input string n, input logic [3:0] a,
                        input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(n, e, rdata);
  endtask

  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #100000;
    error_cnt++;
    $display("[ERR] watchdog expected end seen hang");
    stop_test();
  end

  initial begin
    int n;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    exp_st("reset state", 6'h20);
    rd_reg("sysctrl reset", `CSWL_OFF_SYSCTRL, `CSWL_SYSCTRL_RST);
    rd_reg("id", `CSWL_OFF_ID, `CSWL_ID_VALUE);
    wr_reg(`CSWL_OFF_SYSCTRL, 32'hFFFF_FFFF);
    rd_reg("sysctrl bits", `CSWL_OFF_SYSCTRL, `CSWL_SYSCTRL_MASK);
    wr_reg(`CSWL_OFF_STATUS, 32'hFFFF_FFFF);
    rd_reg("status ro", `CSWL_OFF_STATUS, 32'h0);
    rd_reg("unmapped", 4'hC, 32'h0);
    wr_reg(`CSWL_OFF_SYSCTRL, 32'h0);
    $display("registers done");
    pulse(0);
    exp_st("irq sleep light", 6'h14);
    pulse(6);
    hold("irq sleep ignores event", 6'h14);
    setlv(7'h08);
    exp_st("irq sleep wake", 6'h20);
    setlv(7'h00);
    pulse(1);
    hold("latch from sleep", 6'h20);
    $display("irq sleep done");
    pulse(6);
    rd_reg("latch hidden", `CSWL_OFF_STATUS, 32'h0);
    n = cons_cnt;
    pulse(1);
    hold("evt latch set", 6'h20);
    chk("consumed", n + 1, cons_cnt);
    pulse(1);
    exp_st("evt latch clear", 6'h14);
    pulse(7);
    exp_st("evt peer wake", 6'h20);
    pulse(1);
    exp_st("evt sleep", 6'h14);
    pulse(6);
    exp_st("evt input wake", 6'h20);
    pulse(1);
    exp_st("evt sleep again", 6'h14);
    pulse(5);
    hold("pending off", 6'h14);
    wr_reg(`CSWL_OFF_SYSCTRL, 32'h10);
    pulse(5);
    exp_st("pending wake", 6'h20);
    $display("evt sleep done");
    setlv(7'h08);
    pulse(0);
    hold("irq wake true", 6'h20);
    setlv(7'h00);
    wr_reg(`CSWL_OFF_SYSCTRL, 32'h04);
    pulse(0);
    exp_st("deep", 6'h1E);
    rd_reg("status deep", `CSWL_OFF_STATUS, 32'h6);
    setlv(7'h08);
    exp_st("deep wake", 6'h20);
    setlv(7'h00);
    wr_reg(`CSWL_OFF_SYSCTRL, 32'h02);
    pulse(2);
    exp_st("after handler", 6'h14);
    setlv(7'h07);
    hold("fault_mask_bit held", 6'h14);
    setlv(7'h06);
    exp_st("masked wake", 6'h20);
    setlv(7'h00);
    wr_reg(`CSWL_OFF_SYSCTRL, 32'h0);
    $display("sleep modes done");
    pulse(3);
    hold("fault in thread", 6'h20);
    setlv(7'h20);
    pulse(3);
    exp_st("lockup hf", 6'h01);
    setlv(7'h30);
    exp_st("nmi exit", 6'h20);
    setlv(7'h40);
    pulse(3);
    exp_st("lockup nmi", 6'h01);
    setlv(7'h50);
    hold("nmi ignored", 6'h01);
    rd_reg("status nmi", `CSWL_OFF_STATUS, 32'h9);
    pulse(4);
    exp_st("halt exit", 6'h20);
    setlv(7'h20);
    pulse(3);
    exp_st("lockup before reset", 6'h01);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    exp_st("reset exit", 6'h20);
    setlv(7'h00);
    $display("lockup done");
    stop_test();
  end
endmodule // core_sleep_wake_lockup_ctrl_test
